// [bench/tbcp_checker.sv]
/* checker for tbcp_top: counter, pair 0 linking, irq and 0% duty.
   assumes a constant modulo and pair 0 odd writes only while linked. */
`timescale 1ns/1ns
module tbcp_checker (
   input wire clock,
   input wire rstn,
   input wire [15:0] modulo,
   input wire [5:0] ch_write,
   input wire [7:0] ch0_status_control,
   input wire [7:0] ch2_status_control,
   input wire [15:0] count,
   input wire overflow,
   input wire [5:0] channel_event_flag,
   input wire [5:0] channel_irq,
   input wire [5:0] pin_out,
   input wire [5:0] pin_oe,
   input wire [2:0] odd_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   reg last_odd_q;
   // last written side of pair 0; forgotten on unlink since select goes back to even
   always @(posedge clock) begin
      if (!rstn || !ch0_status_control[5]) last_odd_q <= 1'b0;
      else if (ch_write[1]) last_odd_q <= 1'b1;
      else if (ch_write[0]) last_odd_q <= 1'b0;
   end
   property p_wrap; overflow |=> count == 16'h0000; endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");
   property p_step; rstn && !overflow |=> count == $past(count) + 16'h0001; endproperty
   a_step: assert property (p_step) else $error("counter step wrong");
   property p_ovf; overflow == (count == modulo); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not at modulo");
   property p_even; ch0_status_control[5] && $past(ch0_status_control[5]) |-> pin_oe[0]; endproperty
   a_even: assert property (p_even) else $error("even pin not driven");
   property p_odd; ch0_status_control[5] && $past(ch0_status_control[5]) |-> !pin_oe[1]; endproperty
   a_odd: assert property (p_odd) else $error("odd pin not released");
   property p_hold;
      !$past(overflow) && $past(ch0_status_control[5]) && ch0_status_control[5] |-> $stable(odd_active[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("select moved off overflow");
   property p_sel;
      overflow && ch0_status_control[5] && ch_write[1:0] == 2'b00 |=> odd_active[0] == last_odd_q;
   endproperty
   a_sel: assert property (p_sel) else $error("wrong source after overflow");
   property p_irq; channel_irq[2] == (channel_event_flag[2] && ch2_status_control[6]); endproperty
   a_irq: assert property (p_irq) else $error("irq not flag and enable");
   property p_zero;
      (ch2_status_control[4:1] == 4'b1100 && !pin_out[2]) ##1 $stable(ch2_status_control) |-> !pin_out[2];
   endproperty
   a_zero: assert property (p_zero) else $error("pin moved without toggle");
endmodule
bind tbcp_top tbcp_checker tbcp_checker_inst (.clock(clock), .rstn(rstn), .modulo(modulo),
   .ch_write(ch_write), .ch0_status_control(ch0_status_control), .ch2_status_control(ch2_status_control),
   .count(count), .overflow(overflow), .channel_event_flag(channel_event_flag), .channel_irq(channel_irq),
   .pin_out(pin_out), .pin_oe(pin_oe), .odd_active(odd_active));

// [bench/tbcp_tb_top.sv]
/* self-checking bench for tbcp_top: pulse widths measured over whole periods.
   assumes modulo 255, so one period is 256 clocks. */
`timescale 1ns/1ns
module tbcp_tb_top;
   reg clock = 1'b0;
   reg rstn = 1'b0;
   reg [15:0] ch_value = 16'h0000;
   reg [5:0] ch_write = 6'h00;
   reg [5:0] flag_clear = 6'h00;
   reg [7:0] ctl0 = 8'h00, ctl1 = 8'h00, ctl2 = 8'h00;
   wire [15:0] count;
   wire overflow;
   wire [5:0] flag, irq, pin_out, pin_oe;
   wire [2:0] odd_active;
   integer bad_count = 0, checked = 0;
   tbcp_top tbcp_top_inst (.clock(clock), .rstn(rstn), .modulo(16'h00ff), .ch_value(ch_value),
      .ch_write(ch_write), .ch0_status_control(ctl0), .ch1_status_control(ctl1), .ch2_status_control(ctl2),
      .ch3_status_control(8'h00), .ch4_status_control(8'h00), .ch5_status_control(8'h00),
      .flag_clear(flag_clear), .count(count), .overflow(overflow), .channel_event_flag(flag),
      .channel_irq(irq), .pin_out(pin_out), .pin_oe(pin_oe), .odd_active(odd_active));
   // 50 ns timer clock
   always #25 clock = ~clock;
   ////////////////////////////////////////////////////////////
   task chk(input string nm, input [15:0] ex, input [15:0] got);
      begin
         checked = checked + 1;
         if (got !== ex) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // returns on the edge that ends the count==modulo cycle
   task wait_ovf;
      integer n;
      begin
         n = 0;
         @(posedge clock);
         while (overflow !== 1'b1 && n < 600) begin
            n = n + 1;
            @(posedge clock);
         end
         if (n >= 600) chk("overflow_seen", 16'h0001, 16'h0000);
      end
   endtask
   task wr(input [5:0] m, input [15:0] v);
      begin
         @(posedge clock);
         ch_value <= v;
         ch_write <= m;
         @(posedge clock);
         ch_write <= 6'h00;
      end
   endtask
   // high time of one pin over one period; optional write at clock 100 of it
   task measure(input [2:0] p, input [5:0] wm, input [15:0] wv, input [15:0] ex);
      integer i;
      reg [15:0] hi;
      begin
         hi = 16'h0000;
         wait_ovf;
         for (i = 1; i <= 256; i = i + 1) begin
            @(posedge clock);
            hi = hi + {15'h0000, pin_out[p]};
            ch_write <= (i == 100) ? wm : 6'h00;
            if (i == 100) ch_value <= wv;
            if (i == 256) chk("period_end", 16'h0001, {15'h0000, overflow});
         end
         chk("high_time", ex, hi);
      end
   endtask
   task run2(input [7:0] c, input [15:0] v, input [15:0] ex);
      begin
         ctl2 <= c;
         wr(6'h04, v);
         wait_ovf;
         measure(3'd2, 6'h00, 16'h0000, ex);
      end
   endtask
   ////////////////////////////////////////////////////////////
   // watchdog, about twice the expected run
   initial begin
      #1000000;
      bad_count = bad_count + 1;
      end_sim;
   end
   initial begin
      repeat (12) @(posedge clock);
      chk("reset_pins", 16'h0000, {10'h000, pin_out});
      chk("reset_sel", 16'h0000, {13'h0000, odd_active});
      rstn <= 1'b1;
      run2(8'h5a, 16'h0080, 16'h0080);
      run2(8'h5a, 16'h0040, 16'h0040);
      run2(8'h58, 16'h0080, 16'h0000);
      run2(8'h5b, 16'h0080, 16'h0100);
      run2(8'h5e, 16'h0040, 16'h00c0);
      chk("flag2", 16'h0001, {15'h0000, flag[2]});
      chk("irq2", 16'h0001, {15'h0000, irq[2]});
      flag_clear <= 6'h04;
      @(posedge clock);
      flag_clear <= 6'h00;
      @(posedge clock);
      chk("flag2_clr", 16'h0000, {15'h0000, flag[2]});
      run2(8'h5a, 16'h00c0, 16'h00c0);
      measure(3'd2, 6'h04, 16'h0040, 16'h0100);
      measure(3'd2, 6'h00, 16'h0000, 16'h0040);
      measure(3'd2, 6'h04, 16'h0020, 16'h0040);
      measure(3'd2, 6'h00, 16'h0000, 16'h0020);
      wr(6'h04, 16'h0080);
      measure(3'd2, 6'h00, 16'h0000, 16'h0080);
      $display("unbuffered tests done");
      ctl1 <= 8'h5f;
      wr(6'h01, 16'h0040);
      ctl0 <= 8'h3a;
      wait_ovf;
      measure(3'd0, 6'h00, 16'h0000, 16'h0040);
      chk("odd_oe", 16'h0000, {15'h0000, pin_oe[1]});
      chk("even_oe", 16'h0001, {15'h0000, pin_oe[0]});
      measure(3'd0, 6'h02, 16'h00c0, 16'h0040);
      measure(3'd0, 6'h00, 16'h0000, 16'h00c0);
      chk("sel_odd", 16'h0001, {15'h0000, odd_active[0]});
      measure(3'd0, 6'h01, 16'h0020, 16'h00c0);
      measure(3'd0, 6'h00, 16'h0000, 16'h0020);
      chk("sel_even", 16'h0000, {15'h0000, odd_active[0]});
      $display("buffered tests done");
      end_sim;
   end
endmodule

// [rtl/tbcp_chan.v]
/*
 * one output compare channel: compare detect, pin action, event flag.
 * assumes counter, overflow strobe and active compare value come from the top.
 */
`timescale 1ns/1ns
`include "tbcp_defs.vh"
module tbcp_chan (
   clock,
   rstn,
   count,
   overflow,
   compare_value,
   ctrl,
   flag_clear,
   pin_out,
   flag,
   irq
);
   input wire clock;
   input wire rstn;
   input wire [`TBCP_CNT_W-1:0] count;
   input wire overflow;
   input wire [`TBCP_CNT_W-1:0] compare_value;
   input wire [`TBCP_CTRL_W-1:0] ctrl;
   input wire flag_clear;
   output wire pin_out;
   output wire flag;
   output wire irq;

   reg pin_q;
   reg pin_d;
   reg flag_q;
   wire compare_hit;
   wire output_mode;
   wire [1:0] els;
   wire [`TBCP_CNT_W-1:0] cnt_next;
   wire pin_hit;

   // compare compares the live value, so a write lands at once
   assign compare_hit = (count == compare_value);
   assign els = {ctrl[`TBCP_F_ELSB], ctrl[`TBCP_F_ELSA]};
   // pin acts on the coming count, so a value of n gives n clocks of pulse
   assign cnt_next = overflow ? `TBCP_CNT_RST : count + 16'h0001;
   assign pin_hit = (cnt_next == compare_value);
   // buffered bit or mode a makes this an output compare channel
   assign output_mode = ctrl[`TBCP_F_MSB] | ctrl[`TBCP_F_MSA];

   ////////////////////////////////////////////////////////////////////////
   // pin action: overflow toggle first, compare action wins when same cycle
   always @* begin
      pin_d = pin_q;
      if (output_mode && els != 2'b00) begin
         if (overflow && ctrl[`TBCP_F_TOV]) begin
            pin_d = ~pin_q;
         end
         if (pin_hit) begin
            case (els)
               2'b01: pin_d = ~pin_q;
               2'b10: pin_d = 1'b0;
               2'b11: pin_d = 1'b1;
               default: pin_d = pin_q;
            endcase
         end
         // max duty with overflow toggle holds the pulse level for the whole period
         if (ctrl[`TBCP_F_MAX] && ctrl[`TBCP_F_TOV]) begin
            pin_d = ~els[0];
         end
      end
   end

   always @(posedge clock) begin
      if (!rstn) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event flag: a new compare beats a clear in the same cycle
   always @(posedge clock) begin
      if (!rstn) begin
         flag_q <= 1'b0;
      end else if (output_mode && compare_hit) begin
         flag_q <= 1'b1;
      end else if (flag_clear) begin
         flag_q <= 1'b0;
      end
   end

   assign pin_out = pin_q;
   assign flag = flag_q;
   assign irq = flag_q & ctrl[`TBCP_F_IE];
endmodule

// [rtl/tbcp_defs.vh]
/*
 * constants for the buffered compare / pwm block: counter width, channel
 * count, control field positions and reset values.
 * assumes inclusion by the design files of this block only.
 */
// Notes on behaviour
// - even buffered bit links pair onto even pin
// - on linking, even registers drive the output
// - odd write takes over at next overflow
// - each overflow selects last written register
// - even control configures pair, odd control ignored
// - linked odd pin released to general purpose
// - toggle on overflow at modulo gives period
// - pulse runs from overflow to compare match
// - period equals modulo plus one clocks
// - channel value sets width in timer clocks
// - unbuffered write replaces compare value at once
// - odd value takes effect next period
// - compare sets flag, interrupt when enabled
// - no overflow toggle gives 0%, max with overflow toggle gives 100%
// - buffered bit overrides other mode select bit
`ifndef TBCP_DEFS_VH
`define TBCP_DEFS_VH
`define TBCP_CNT_W 16
`define TBCP_NCH 6
`define TBCP_CTRL_W 8
// control byte field positions
`define TBCP_F_MAX 0
`define TBCP_F_TOV 1
`define TBCP_F_ELSA 2
`define TBCP_F_ELSB 3
`define TBCP_F_MSA 4
`define TBCP_F_MSB 5
`define TBCP_F_IE 6
`define TBCP_CTRL_RST 8'h00
`define TBCP_CNT_RST 16'h0000
`define TBCP_MOD_RST 16'hffff
`endif

// [rtl/tbcp_top.v]
/*
 * six channel buffered compare / pwm block: counter, pair linking,
 * compare source selection and pin enables.
 * assumes software writes arrive as one-cycle strobes in the timer clock.
 */
`timescale 1ns/1ns
`include "tbcp_defs.vh"
module tbcp_top (
   clock,
   rstn,
   modulo,
   ch_value,
   ch_write,
   ch0_status_control,
   ch1_status_control,
   ch2_status_control,
   ch3_status_control,
   ch4_status_control,
   ch5_status_control,
   flag_clear,
   count,
   overflow,
   channel_event_flag,
   channel_irq,
   pin_out,
   pin_oe,
   odd_active
);
   input wire clock;
   input wire rstn;
   input wire [15:0] modulo;
   input wire [15:0] ch_value;
   input wire [5:0] ch_write;
   input wire [7:0] ch0_status_control;
   input wire [7:0] ch1_status_control;
   input wire [7:0] ch2_status_control;
   input wire [7:0] ch3_status_control;
   input wire [7:0] ch4_status_control;
   input wire [7:0] ch5_status_control;
   input wire [5:0] flag_clear;
   output wire [15:0] count;
   output wire overflow;
   output wire [5:0] channel_event_flag;
   output wire [5:0] channel_irq;
   output wire [5:0] pin_out;
   output wire [5:0] pin_oe;
   output wire [2:0] odd_active;

   reg [15:0] count_q;
   reg [15:0] value_q [0:5];
   reg [2:0] sel_odd_q;
   reg [2:0] last_odd_q;
   wire [47:0] ctrl_all;
   wire [2:0] linked;
   integer i;

   assign ctrl_all = {ch5_status_control, ch4_status_control, ch3_status_control,
                      ch2_status_control, ch1_status_control, ch0_status_control};
   // buffered bit sits in each even control byte only
   assign linked = {ch4_status_control[`TBCP_F_MSB], ch2_status_control[`TBCP_F_MSB],
                    ch0_status_control[`TBCP_F_MSB]};

   ////////////////////////////////////////////////////////////////////////
   // modulo counter, period is modulo plus one clocks
   assign overflow = (count_q == modulo);
   always @(posedge clock) begin
      if (!rstn) begin
         count_q <= `TBCP_CNT_RST;
      end else if (overflow) begin
         count_q <= `TBCP_CNT_RST;
      end else begin
         count_q <= count_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel value registers; written values act at once when unbuffered
   always @(posedge clock) begin
      if (!rstn) begin
         for (i = 0; i < 6; i = i + 1) begin
            value_q[i] <= 16'h0000;
         end
      end else begin
         for (i = 0; i < 6; i = i + 1) begin
            if (ch_write[i]) begin
               value_q[i] <= ch_value;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source select: remember last written half, switch at overflow, back to even at once on unlink
   always @(posedge clock) begin
      if (!rstn) begin
         sel_odd_q <= 3'h0;
         last_odd_q <= 3'h0;
      end else begin
         for (i = 0; i < 3; i = i + 1) begin
            if (!linked[i]) begin
               // unlinked pair restarts on even registers when linked again
               sel_odd_q[i] <= 1'b0;
               last_odd_q[i] <= 1'b0;
            end else begin
               if (ch_write[2*i+1]) begin
                  last_odd_q[i] <= 1'b1;
               end else if (ch_write[2*i]) begin
                  last_odd_q[i] <= 1'b0;
               end
               if (overflow) begin
                  sel_odd_q[i] <= last_odd_q[i];
               end
            end
         end
      end
   end
   assign odd_active = sel_odd_q;

   ////////////////////////////////////////////////////////////////////////
   // per channel engines; odd channel of a linked pair sits idle
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : gen_ch
         wire [15:0] cmp_v;
         wire [7:0] ctrl_v;
         if (g % 2 == 0) begin : gen_even
            assign cmp_v = sel_odd_q[g/2] ? value_q[g+1] : value_q[g];
            assign ctrl_v = ctrl_all[8*g +: 8];
            assign pin_oe[g] = linked[g/2] | ctrl_v[`TBCP_F_MSA] |
                               (ctrl_v[`TBCP_F_ELSB] | ctrl_v[`TBCP_F_ELSA]) & ctrl_v[`TBCP_F_MSA];
         end else begin : gen_odd
            assign cmp_v = value_q[g];
            // odd control ignored while linked
            assign ctrl_v = linked[g/2] ? `TBCP_CTRL_RST : ctrl_all[8*g +: 8];
            assign pin_oe[g] = ~linked[g/2] & ctrl_v[`TBCP_F_MSA];
         end
         tbcp_chan u_chan (
            .clock(clock),
            .rstn(rstn),
            .count(count_q),
            .overflow(overflow),
            .compare_value(cmp_v),
            .ctrl(ctrl_v),
            .flag_clear(flag_clear[g]),
            .pin_out(pin_out[g]),
            .flag(channel_event_flag[g]),
            .irq(channel_irq[g])
         );
      end
   endgenerate

   assign count = count_q;
endmodule
